// *** rtl/pdbb_bus_buffer.sv ***
// eight-bit buffered data path between host port and connectors
//
// Notes on behaviour
// RULE_01: eight data lines pass through buffers between host and connectors.
// RULE_02: direction is fixed out, fixed in, or follows the host select line.
// RULE_03: bit zero is the lowest terminal and bit seven the highest.
// RULE_04: all eight lines always share one direction.
// RULE_05: each line has a pull-up and an indicator lit while it is low.
// RULE_06: host drives lines when out, connector equipment drives them when in.
// RULE_07: disabled in output mode, every connector line shows high.
// RULE_08: in input mode an undriven connector line reads high at the host.
// RULE_09: estop, fault and watchdog may disable the buffers per jumpers.
// RULE_10: always-enabled setting ignores estop, fault and watchdog.
// RULE_11: gated setting enables buffers only while outputs-ok is active.
// RULE_12: follow mode drives connectors on select high, host on select low.
// RULE_13: outputs-ok needs fault high, optionally estop off and watchdog good.
`timescale 1ns/1ps
module pdbb_bus_buffer
  import pdbb_pkg::*;
#(
  parameter int unsigned DATA_W = PDBB_DATA_W
)
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // jumpers
  input wire logic bus_enable_jumper_i,
  input wire logic ok_source_jumper_i,
  input wire logic [1:0] bus_direction_jumper_i,
  input wire logic estop_normal_i,
  // safety inputs
  input wire logic fault_n_i,
  input wire logic estop_i,
  input wire logic cp_ok_i,
  // host port side
  input wire logic select_in_i,
  input wire logic [DATA_W-1:0] host_data_i,
  output logic [DATA_W-1:0] host_data_o,
  output logic [DATA_W-1:0] host_data_oe_n_o,
  // connector side
  input wire logic [DATA_W-1:0] conn_data_i,
  input wire logic [DATA_W-1:0] conn_driven_i,
  output logic [DATA_W-1:0] conn_data_o,
  output logic [DATA_W-1:0] conn_data_oe_n_o,
  // indicators
  output logic [DATA_W-1:0] line_led_n_o,
  output logic ok_led_o,
  // register port
  input wire logic [PDBB_ADDR_W-1:0] reg_addr_i,
  input wire logic [PDBB_REG_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [PDBB_REG_W-1:0] reg_rdata_o
);

  pdbb_cfg_t cfg;
  pdbb_safety_t safety;
  logic ok;
  logic dir_out;
  logic bus_en;

  pdbb_lines_t host_d;
  pdbb_lines_t host_q;
  pdbb_lines_t conn_d;
  pdbb_lines_t conn_q;
  logic [DATA_W-1:0] conn_level;
  logic [DATA_W-1:0] line_level;
  logic [DATA_W-1:0] led_n_d;
  logic [DATA_W-1:0] led_n_q;
  logic ok_led_q;

  logic [1:0] ctrl_q;
  logic ok_lost_q;
  logic ok_lost_clr;
  logic [PDBB_REG_W-1:0] rdata_d;
  logic [PDBB_REG_W-1:0] rdata_q;

  // gather jumpers and safety inputs
  always_comb
  begin
    cfg.bus_enable_jumper = bus_enable_jumper_i;
    cfg.ok_source_jumper = ok_source_jumper_i;
    cfg.estop_normal = estop_normal_i;
    case (bus_direction_jumper_i)
      2'h1: cfg.bus_direction_jumper = PDBB_DIR_OUT;
      2'h2: cfg.bus_direction_jumper = PDBB_DIR_FOLLOW;
      default: cfg.bus_direction_jumper = PDBB_DIR_OPEN;
    endcase
    safety.fault_n = fault_n_i;
    safety.estop = estop_i;
    safety.cp_ok = cp_ok_i;
  end

  pdbb_ok_gen u_ok_gen (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .cfg_i(cfg),
    .safety_i(safety),
    .ok_o(ok)
  );

  pdbb_dir_ctrl u_dir_ctrl (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .cfg_i(cfg),
    .select_in_i(select_in_i),
    .ok_i(ok),
    .dir_out_o(dir_out),
    .bus_en_o(bus_en)
  );

  // connector level after its pull-up
  assign conn_level = pdbb_pulled(conn_driven_i, conn_data_i); // see RULE_08

  // line level that the indicators watch
  always_comb
  begin
    // lock-out releases the connectors, so the pull-ups win
    if (dir_out && bus_en && !ctrl_q[PDBB_CTRL_LOCK_OUT])
    begin
      line_level = host_data_i; // see RULE_06
    end
    else if (dir_out)
    begin
      line_level = PDBB_LINES_HIGH; // see RULE_07
    end
    else
    begin
      line_level = conn_level; // see RULE_06
    end
  end

  // buffer path, same direction for every bit
  always_comb
  begin
    host_d.level = PDBB_LINES_HIGH;
    host_d.oe_n = PDBB_OE_N_OFF;
    conn_d.level = PDBB_LINES_HIGH;
    conn_d.oe_n = PDBB_OE_N_OFF;
    if (bus_en && dir_out && !ctrl_q[PDBB_CTRL_LOCK_OUT])
    begin
      // toward connectors, bit index kept so lsb is lowest terminal
      conn_d.level = host_data_i; // see RULE_01
      conn_d.oe_n = PDBB_OE_N_ON; // see RULE_04
    end
    else if (bus_en && !dir_out)
    begin
      // toward host, undriven lines read high
      host_d.level = conn_level; // see RULE_08
      host_d.oe_n = PDBB_OE_N_ON; // see RULE_04
    end
    else if (dir_out)
    begin
      // released, pull-ups hold the connector high
      conn_d.level = PDBB_LINES_HIGH; // see RULE_07
    end
  end

  // output lines
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      host_q.level <= PDBB_LINES_HIGH;
      host_q.oe_n <= PDBB_OE_N_OFF;
      conn_q.level <= PDBB_LINES_HIGH;
      conn_q.oe_n <= PDBB_OE_N_OFF;
    end
    else
    begin
      host_q <= host_d; // see RULE_01
      conn_q <= conn_d; // see RULE_03
    end
  end

  // indicators lit while the line is low
  always_comb
  begin
    if (ctrl_q[PDBB_CTRL_LED_EN])
    begin
      led_n_d = line_level; // see RULE_05
    end
    else
    begin
      led_n_d = PDBB_LINES_HIGH;
    end
  end

  // indicator flops
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      led_n_q <= PDBB_LINES_HIGH;
      ok_led_q <= 1'b0;
    end
    else
    begin
      led_n_q <= led_n_d; // see RULE_05
      ok_led_q <= ok; // see RULE_11
    end
  end

  // control register
  // bit zero lights the indicators, bit one locks the output path off
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      ctrl_q <= PDBB_CTRL_RST;
    end
    else if (reg_we_i && reg_addr_i == PDBB_OFS_CTRL)
    begin
      ctrl_q <= reg_wdata_i[PDBB_CTRL_LOCK_OUT:PDBB_CTRL_LED_EN];
    end
  end

  // writing one to the status lost bit clears it
  assign ok_lost_clr = reg_we_i && reg_addr_i == PDBB_OFS_STATUS &&
                       reg_wdata_i[PDBB_ST_OK_LOST];

  // sticky record that outputs-ok dropped, set wins over clear
  // a drop and a clear in one cycle leave the bit set
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      ok_lost_q <= 1'b0;
    end
    else if (ok_led_q && !ok)
    begin
      ok_lost_q <= 1'b1;
    end
    else if (ok_lost_clr)
    begin
      ok_lost_q <= 1'b0;
    end
  end

  // read mux, unmapped offsets read zero
  always_comb
  begin
    rdata_d = '0;
    case (reg_addr_i)
      PDBB_OFS_CTRL:
      begin
        rdata_d[PDBB_CTRL_LOCK_OUT:PDBB_CTRL_LED_EN] = ctrl_q;
      end
      PDBB_OFS_STATUS:
      begin
        rdata_d[PDBB_ST_OK] = ok;
        rdata_d[PDBB_ST_BUS_EN] = bus_en;
        rdata_d[PDBB_ST_DIR_OUT] = dir_out;
        rdata_d[PDBB_ST_EN_JMP] = bus_enable_jumper_i;
        rdata_d[PDBB_ST_OK_JMP] = ok_source_jumper_i;
        rdata_d[PDBB_ST_DIR_JMP +: PDBB_ST_DIR_JMP_W] = bus_direction_jumper_i;
        rdata_d[PDBB_ST_OK_LOST] = ok_lost_q;
      end
      PDBB_OFS_LEVELS:
      begin
        rdata_d[PDBB_LV_CONN +: PDBB_DATA_W] = line_level;
        rdata_d[PDBB_LV_HOST +: PDBB_DATA_W] = host_data_i;
      end
      PDBB_OFS_ID:
      begin
        rdata_d = PDBB_ID_VALUE;
      end
      default:
      begin
        rdata_d = '0;
      end
    endcase
  end

  // read data valid only in the cycle after the strobe
  // zero between reads so a stale word is never taken twice
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      rdata_q <= '0;
    end
    else if (reg_re_i)
    begin
      rdata_q <= rdata_d;
    end
    else
    begin
      rdata_q <= '0;
    end
  end

  // ports straight from flops
  assign host_data_o = host_q.level;
  assign host_data_oe_n_o = host_q.oe_n;
  assign conn_data_o = conn_q.level;
  assign conn_data_oe_n_o = conn_q.oe_n;
  assign line_led_n_o = led_n_q;
  assign ok_led_o = ok_led_q;
  assign reg_rdata_o = rdata_q;

endmodule : pdbb_bus_buffer

// *** rtl/pdbb_dir_ctrl.sv ***
// bus direction and buffer enable decision
`timescale 1ns/1ps
module pdbb_dir_ctrl
  import pdbb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire pdbb_cfg_t cfg_i,
  input wire logic select_in_i,
  input wire logic ok_i,
  output logic dir_out_o,
  output logic bus_en_o
);

  logic dir_out_d;
  logic dir_out_q;
  logic bus_en_d;
  logic bus_en_q;

  // one direction for the whole bus
  always_comb
  begin
    case (cfg_i.bus_direction_jumper)
      PDBB_DIR_OUT: dir_out_d = 1'b1; // see RULE_02
      PDBB_DIR_FOLLOW: dir_out_d = select_in_i; // see RULE_12
      PDBB_DIR_OPEN: dir_out_d = 1'b0; // see RULE_02
      default: dir_out_d = 1'b0;
    endcase
  end

  // always enabled or gated by the ok signal
  always_comb
  begin
    if (cfg_i.bus_enable_jumper)
    begin
      bus_en_d = 1'b1; // see RULE_10
    end
    else
    begin
      bus_en_d = ok_i; // see RULE_11
    end
  end

  // registered decision, bus disabled and input during reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      dir_out_q <= 1'b0;
      bus_en_q <= 1'b0;
    end
    else
    begin
      dir_out_q <= dir_out_d; // see RULE_04
      bus_en_q <= bus_en_d; // see RULE_09
    end
  end

  assign dir_out_o = dir_out_q;
  assign bus_en_o = bus_en_q;

endmodule : pdbb_dir_ctrl

// *** rtl/pdbb_ok_gen.sv ***
// combined outputs-ok generation
`timescale 1ns/1ps
module pdbb_ok_gen
  import pdbb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire pdbb_cfg_t cfg_i,
  input wire pdbb_safety_t safety_i,
  output logic ok_o
);

  logic ok_d;
  logic ok_q;

  // fault must be high; estop and watchdog only when selected
  always_comb
  begin
    ok_d = safety_i.fault_n; // see RULE_13
    if (cfg_i.estop_normal && safety_i.estop)
    begin
      ok_d = 1'b0; // see RULE_13
    end
    if (cfg_i.ok_source_jumper && !safety_i.cp_ok)
    begin
      ok_d = 1'b0; // see RULE_13
    end
  end

  // held low through reset so the bus starts safe
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      ok_q <= 1'b0;
    end
    else
    begin
      ok_q <= ok_d;
    end
  end

  assign ok_o = ok_q;

endmodule : pdbb_ok_gen

// *** rtl/pdbb_pkg.sv ***
// shared types and constants for the parallel data bus buffer
package pdbb_pkg;

  // data bus width and bit positions
  localparam int unsigned PDBB_DATA_W = 8;
  localparam int unsigned PDBB_DATA_BIT_LSB = 0;
  localparam int unsigned PDBB_DATA_BIT_MSB = 7;

  // register port geometry
  localparam int unsigned PDBB_ADDR_W = 4;
  localparam int unsigned PDBB_REG_W = 32;

  // register offsets
  localparam logic [3:0] PDBB_OFS_CTRL = 4'h0;
  localparam logic [3:0] PDBB_OFS_STATUS = 4'h4;
  localparam logic [3:0] PDBB_OFS_LEVELS = 4'h8;
  localparam logic [3:0] PDBB_OFS_ID = 4'hc;

  // control register fields and reset value
  localparam int unsigned PDBB_CTRL_LED_EN = 0;
  localparam int unsigned PDBB_CTRL_LOCK_OUT = 1;
  localparam logic [1:0] PDBB_CTRL_RST = 2'h1;

  // status register fields
  localparam int unsigned PDBB_ST_OK = 0;
  localparam int unsigned PDBB_ST_BUS_EN = 1;
  localparam int unsigned PDBB_ST_DIR_OUT = 2;
  localparam int unsigned PDBB_ST_EN_JMP = 3;
  localparam int unsigned PDBB_ST_OK_JMP = 4;
  localparam int unsigned PDBB_ST_DIR_JMP = 5;
  localparam int unsigned PDBB_ST_DIR_JMP_W = 2;
  localparam int unsigned PDBB_ST_OK_LOST = 7;

  // levels register fields
  localparam int unsigned PDBB_LV_CONN = 0;
  localparam int unsigned PDBB_LV_HOST = 8;

  // block identity word, value is arbitrary
  localparam logic [31:0] PDBB_ID_VALUE = 32'h0000_5a01;

  // reset values of the line groups and the oe_n value that enables driving
  localparam logic [7:0] PDBB_LINES_HIGH = 8'hff;
  localparam logic [7:0] PDBB_OE_N_OFF = 8'hff;
  localparam logic [7:0] PDBB_OE_N_ON = 8'h00;

  // direction jumper positions
  typedef enum logic [1:0] {
    PDBB_DIR_OPEN,
    PDBB_DIR_OUT,
    PDBB_DIR_FOLLOW
  } pdbb_dir_sel_t;

  // jumper inputs travel together, safety inputs in the next bundle
  typedef struct packed {
    logic bus_enable_jumper;
    logic ok_source_jumper;
    pdbb_dir_sel_t bus_direction_jumper;
    logic estop_normal;
  } pdbb_cfg_t;

  typedef struct packed {
    logic fault_n;
    logic estop;
    logic cp_ok;
  } pdbb_safety_t;

  // a bundle of open-drain style line signals
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_n;
  } pdbb_lines_t;

  // level seen on a line with its pull-up
  function automatic logic [7:0] pdbb_pulled(input logic [7:0] driven,
                                              input logic [7:0] level);
    pdbb_pulled = (driven & level) | ~driven;
  endfunction : pdbb_pulled

endpackage : pdbb_pkg

// *** test/pdbb_bus_buffer_tb.sv ***
// self-checking bench for the parallel data bus buffer
`timescale 1ns/1ps
module pdbb_bus_buffer_tb;
  import pdbb_pkg::*;
  typedef struct {int due; int k; logic [31:0] e;} pdbb_note_t;
  pdbb_note_t nq[$];
  string nm[7] = '{"conn_data", "conn_oe_n", "host_data", "host_oe_n",
    "line_led_n", "ok_led", "reg_rdata"};
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic enj = 1'b0, okj = 1'b1, estn = 1'b1, fn = 1'b1, es = 1'b0;
  logic cp = 1'b1, sel = 1'b0, we = 1'b0, re = 1'b0, ld = 1'b1, okl;
  logic lk = 1'b0;
  logic [1:0] dir = 2'h1;
  logic [3:0] adr = 4'h0;
  logic [7:0] hdi = 8'h00, plv = 8'h00, pdr = 8'h00, r;
  logic [7:0] cdi, cdr, hdo, hoe, cdo, coe, led;
  logic [7:0] pv[6];
  logic [31:0] wd = 32'h0, rd;
  int cyc = 0, fails = 0, total_checks = 0;

  pdbb_bus_buffer uut (.clk_sys_i, .resetn_i, .bus_enable_jumper_i(enj),
    .ok_source_jumper_i(okj), .bus_direction_jumper_i(dir),
    .estop_normal_i(estn), .fault_n_i(fn), .estop_i(es), .cp_ok_i(cp),
    .select_in_i(sel), .host_data_i(hdi), .host_data_o(hdo),
    .host_data_oe_n_o(hoe), .conn_data_i(cdi), .conn_driven_i(cdr),
    .conn_data_o(cdo), .conn_data_oe_n_o(coe), .line_led_n_o(led),
    .ok_led_o(okl), .reg_addr_i(adr), .reg_wdata_i(wd), .reg_we_i(we),
    .reg_re_i(re), .reg_rdata_o(rd));
  pdbb_far_end far (.clk_sys_i, .drive_i(pdr), .level_i(plv),
    .conn_data_o(cdi), .conn_driven_o(cdr));

  // port values in note kind order
  always_comb pv = '{cdo, coe, hdo, hoe, led, {7'h0, okl}};
  // free-running clock and cycle count
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) cyc <= cyc + 1;

  task automatic cmp8(input int k, input logic [7:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm[k], e, g);
    end
  endtask : cmp8
  task automatic cmp32(input int k, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm[k], e, g);
    end
  endtask : cmp32
  task automatic note(input int k, l, input logic [31:0] e);
    nq.push_back('{cyc + 1 + l, k, e});
  endtask : note
  task automatic finish_test();
    fails += nq.size();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // take due notes off the queue and compare
  always @(posedge clk_sys_i)
  begin
    pdbb_note_t n;
    #1;
    if (cyc > 4000)
    begin
      fails++;
      finish_test();
    end
    else
    begin
      while (nq.size() > 0 && nq[0].due <= cyc)
      begin
        n = nq.pop_front();
        if (n.k < 6)
          cmp8(n.k, n.e[7:0], pv[n.k]);
        else
          cmp32(n.k, n.e, rd);
      end
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    we <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge clk_sys_i);
    we <= 1'b0;
  endtask : wr
  task automatic rdx(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    re <= 1'b1;
    adr <= a;
    note(6, 1, e);
    @(posedge clk_sys_i);
    re <= 1'b0;
  endtask : rdx

  // let inputs settle, then note the whole port picture
  task automatic settle();
    logic ok, en, out;
    logic [7:0] pl, ln;
    repeat (6) @(posedge clk_sys_i);
    ok = fn & (~estn | ~es) & (~okj | cp);
    en = enj | ok;
    out = dir == 2'h1 || (dir == 2'h2 && sel);
    pl = plv | ~pdr;
    ln = out ? (en && !lk ? hdi : 8'hff) : pl;
    note(0, 0, {24'h0, out && en && !lk ? hdi : 8'hff});
    note(1, 0, {24'h0, out && en && !lk ? 8'h00 : 8'hff});
    note(2, 0, {24'h0, !out && en ? pl : 8'hff});
    note(3, 0, {24'h0, !out && en ? 8'h00 : 8'hff});
    note(4, 0, {24'h0, ld ? ln : 8'hff});
    note(5, 0, {31'h0, ok});
    rdx(PDBB_OFS_LEVELS, {16'h0, hdi, ln});
  endtask : settle

  // main sequence
  initial
  begin
    void'($urandom(22));
    repeat (8) @(posedge clk_sys_i);
    note(1, 0, 32'hff);
    note(5, 0, 32'h0);
    resetn_i <= 1'b1;
    rdx(PDBB_OFS_CTRL, 32'h1);
    rdx(PDBB_OFS_ID, PDBB_ID_VALUE);
    rdx(4'h1, 32'h0);
    // lone one on the even bits, lone zero on the odd bits, gated output mode
    for (int k = 0; k < 8; k++)
    begin
      hdi <= k[0] ? ~(8'h01 << k) : 8'h01 << k;
      settle();
    end
    // fault while gated: ok indicator then bus drop
    @(posedge clk_sys_i);
    fn <= 1'b0;
    note(5, 1, 32'h1);
    note(5, 2, 32'h0);
    note(0, 3, 32'hff);
    note(1, 3, 32'hff);
    settle();
    // status shows the drop, a written one clears the sticky bit
    rdx(PDBB_OFS_STATUS, 32'hb4);
    wr(PDBB_OFS_STATUS, 32'h80);
    rdx(PDBB_OFS_STATUS, 32'h34);
    // every direction and enable setting, random safety and data
    for (int k = 0; k < 128; k++)
    begin
      r = 8'($urandom);
      dir <= k[1:0];
      enj <= k[2];
      fn <= k[3];
      sel <= r[0];
      es <= r[1];
      cp <= r[2];
      okj <= r[3];
      estn <= r[4];
      hdi <= 8'($urandom);
      plv <= 8'($urandom);
      pdr <= (k[1:0] == 2'h1 || (k[1:0] == 2'h2 && r[0])) ? 8'h00 :
        8'($urandom);
      settle();
    end
    // indicators off through the control register
    wr(PDBB_OFS_CTRL, 32'h0);
    ld = 1'b0;
    settle();
    rdx(PDBB_OFS_CTRL, 32'h0);
    // lock-out in always-enabled output mode releases the connectors
    dir <= 2'h1;
    enj <= 1'b1;
    wr(PDBB_OFS_CTRL, 32'h3);
    ld = 1'b1;
    lk = 1'b1;
    settle();
    rdx(PDBB_OFS_CTRL, 32'h3);
    // let the last read be compared before the verdict
    repeat (2) @(posedge clk_sys_i);
    finish_test();
  end
endmodule : pdbb_bus_buffer_tb

// *** test/pdbb_chk_assertions.sv ***
// port checker for the parallel data bus buffer
`timescale 1ns/1ps
module pdbb_chk
  import pdbb_pkg::*;
#(
  parameter int unsigned DATA_W = PDBB_DATA_W
)
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic bus_enable_jumper_i,
  input wire logic fault_n_i,
  input wire logic [DATA_W-1:0] host_data_i,
  input wire logic [DATA_W-1:0] host_data_o,
  input wire logic [DATA_W-1:0] host_data_oe_n_o,
  input wire logic [DATA_W-1:0] conn_data_i,
  input wire logic [DATA_W-1:0] conn_driven_i,
  input wire logic [DATA_W-1:0] conn_data_o,
  input wire logic [DATA_W-1:0] conn_data_oe_n_o,
  input wire logic [DATA_W-1:0] line_led_n_o,
  input wire logic ok_led_o,
  input wire logic reg_re_i,
  input wire logic [PDBB_REG_W-1:0] reg_rdata_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  logic [DATA_W-1:0] lvl;
  logic on_c;
  logic on_h;
  // line level and which side is driven
  assign lvl = conn_data_o & host_data_o;
  assign on_c = conn_data_oe_n_o == '0;
  assign on_h = host_data_oe_n_o == '0;
  a_oe_uniform: assert property ((on_c || &conn_data_oe_n_o)
    && (on_h || &host_data_oe_n_o)) else $error("oe split");
  a_one_side: assert property (!(on_c && on_h))
    else $error("both sides driven");
  a_conn_idle: assert property (&conn_data_oe_n_o |-> &conn_data_o)
    else $error("conn idle low");
  a_host_idle: assert property (&host_data_oe_n_o |-> &host_data_o)
    else $error("host idle low");
  a_out_path: assert property (on_c && $past(on_c)
    |-> conn_data_o == $past(host_data_i)) else $error("out data");
  a_in_path: assert property (on_h && $past(on_h)
    |-> host_data_o == $past(conn_data_i | ~conn_driven_i))
    else $error("in data");
  a_led_line: assert property (($stable(lvl) && (on_c || on_h))[*4]
    |-> line_led_n_o == lvl || &line_led_n_o) else $error("led level");
  a_ok_fault: assert property (ok_led_o |-> $past(fault_n_i, 2))
    else $error("ok lit in fault");
  a_gate_off: assert property ($fell(fault_n_i) && !bus_enable_jumper_i
    ##1 (!bus_enable_jumper_i && !fault_n_i)[*2] |-> ##1 &conn_data_oe_n_o)
    else $error("gated bus still on");
  a_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == '0)
    else $error("rdata not idle");
  c_gate_off: cover property ($fell(fault_n_i) && !bus_enable_jumper_i);
  c_in_on: cover property (on_h);
  c_ok_on: cover property ($rose(ok_led_o));
endmodule : pdbb_chk

bind pdbb_bus_buffer pdbb_chk #(.DATA_W(DATA_W)) u_chk (.clk_sys_i,
  .resetn_i, .bus_enable_jumper_i, .fault_n_i, .host_data_i, .host_data_o,
  .host_data_oe_n_o, .conn_data_i, .conn_driven_i, .conn_data_o,
  .conn_data_oe_n_o, .line_led_n_o, .ok_led_o, .reg_re_i, .reg_rdata_o);

// *** test/pdbb_far_end.sv ***
// connector-side equipment model
`timescale 1ns/1ps
module pdbb_far_end
  import pdbb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [7:0] drive_i,
  input wire logic [7:0] level_i,
  output logic [7:0] conn_data_o,
  output logic [7:0] conn_driven_o
);
  logic [7:0] last_q = 8'h00;
  // remember what each driven line last showed
  always_ff @(posedge clk_sys_i)
  begin
    last_q <= (drive_i & level_i) | (~drive_i & last_q);
  end
  // released lines show the inverse, never a stale level
  assign conn_driven_o = drive_i;
  assign conn_data_o = (drive_i & level_i) | (~drive_i & ~last_q);
endmodule : pdbb_far_end
